//--- include/acx_pkg.sv
package acx_pkg;
  // core counts: four dedicated cores plus the shared core at the top index
  localparam int unsigned NUM_DED = 4;
  localparam int unsigned NUM_CORES = 5;
  localparam int unsigned NUM_AN = 22;
  localparam int unsigned EIST_LO_W = 16;
  localparam int unsigned EIST_HI_W = NUM_AN - EIST_LO_W;
  localparam int unsigned DLY_W = 16;
  localparam int unsigned WARM_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SEL_W = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INSEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PWRRDY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WARMCIE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EIST_LO = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EIST_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RDY_ST = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RDY_MASK = 8'h1c;

  // field positions inside the 16-bit registers
  localparam int unsigned SHR_POS = 7;
  localparam int unsigned WARM_LSB = 8;
  localparam int unsigned DIFF_POS [NUM_DED] = '{1, 3, 5, 7};
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [SEL_W-1:0] SEL_NEG_CODE = 2'h1;

  // route codes driven toward the analog front end
  typedef logic [5:0] acx_route_t;
  localparam acx_route_t ROUTE_BANDGAP = 6'h20;
  localparam acx_route_t ROUTE_GAIN1 = 6'h21;
  localparam acx_route_t ROUTE_GAIN2 = 6'h22;
  localparam acx_route_t ROUTE_ALT0 = 6'h23;
  localparam acx_route_t ROUTE_ALT1 = 6'h24;
  localparam acx_route_t ROUTE_NONE = 6'h3f;
  // per selector code, indexed by core number
  localparam acx_route_t ROUTE_CODE0 [NUM_DED] = '{6'h00, 6'h01, 6'h02, 6'h03};
  localparam acx_route_t ROUTE_CODE1 [NUM_DED] = '{6'h07, 6'h12, 6'h0b, 6'h0f};
  localparam acx_route_t ROUTE_CODE2 [NUM_DED] =
    '{ROUTE_GAIN1, ROUTE_GAIN2, ROUTE_BANDGAP, ROUTE_NONE};
  localparam acx_route_t ROUTE_CODE3 [NUM_DED] =
    '{ROUTE_ALT0, ROUTE_ALT1, ROUTE_NONE, ROUTE_NONE};

  // bus data-phase tracker
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR = 4'b0010,
    ST_RD_WAIT = 4'b0100,
    ST_RD_OUT = 4'b1000
  } acx_phase_e;
endpackage

//--- include/acx_warm_if.sv
`timescale 1ns/1ps
interface acx_warm_if;
  import acx_pkg::*;
  logic pwr_en; // core power enable
  logic [DLY_W-1:0] delay_m1; // warm-up length minus one
  logic ready; // warm-up complete
  logic ready_rise; // one-cycle pulse as ready goes high
  modport ctrl (output pwr_en, output delay_m1, input ready, input ready_rise);
  modport timer (input pwr_en, input delay_m1, output ready, output ready_rise);
endinterface

//--- rtl/acx_warm_timer.sv
`timescale 1ns/1ps
module acx_warm_timer import acx_pkg::*; (
  input wire logic core_clk, // core source clock
  input wire logic reset, // synchronous, active high
  acx_warm_if.timer wp // enable in, ready out
);
  logic [DLY_W-1:0] cnt_r; // elapsed warm-up periods
  logic rdy_r; // warm-up done
  logic rise_r; // ready event pulse
  logic done; // last warm-up period reached

  // >= rather than == so a shortened delay mid-count still finishes
  assign done = wp.pwr_en && !rdy_r && (cnt_r >= wp.delay_m1);
  assign wp.ready = rdy_r;
  assign wp.ready_rise = rise_r;

  // period counter, restarts whenever power is removed
  always_ff @(posedge core_clk) begin
    if (reset || !wp.pwr_en) begin
      cnt_r <= '0;
    end else if (!rdy_r && !done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ready flag and its event pulse
  always_ff @(posedge core_clk) begin
    if (reset || !wp.pwr_en) begin
      rdy_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      if (done) begin
        rdy_r <= 1'b1;
      end
      rise_r <= done;
    end
  end

  sequence warm_done_s;
    wp.pwr_en && !rdy_r && cnt_r == wp.delay_m1;
  endsequence

  warm_rise_a: assert property (@(posedge core_clk) disable iff (reset)
    warm_done_s ##1 wp.pwr_en |-> rdy_r && rise_r)
    else $error("ready did not follow warm-up end");
  warm_len_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(rdy_r) |-> $past(cnt_r) >= $past(wp.delay_m1))
    else $error("ready rose before warm-up delay");
endmodule

//--- rtl/acx_core_ctrl.sv
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Contract
// - core 3 selector: 00 AN3, 01 AN15
// - core 2 selector: AN2, AN11, band-gap
// - differential bit makes code 01 negative
// - ready reads one only when powered, ready
// - ready flags hardware only, writes ignored
// - warm-up code sets shared doubling delay
// - early status bits for inputs 0-15
// - inputs 16-21 in upper status bits 5:0
// - result buffer read clears early status
// - unused bits read zero, ignore writes
module acx_core_ctrl import acx_pkg::*; #(
  parameter int unsigned WARM_MAX_LOG2 = 15 // caps the warm-up length
) (
  input wire logic core_clk, // core source clock
  input wire logic reset, // synchronous, active high
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic hready, // ahb bus ready
  input wire logic [31:0] hwdata, // ahb write data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic [31:0] hrdata, // ahb read data
  input wire logic [NUM_AN-1:0] early_irq_evt, // early event per input
  input wire logic [NUM_AN-1:0] result_buf_rd, // result buffer read per input
  output logic [NUM_DED-1:0][5:0] core_route, // selected input per core
  output logic [NUM_DED-1:0] core_neg_sel, // route is a negative input
  output logic [NUM_CORES-1:0] core_power_en, // power enables, shared on top
  output logic [NUM_CORES-1:0] core_ready, // ready flags, shared on top
  output logic irq // common converter interrupt
);

  // an absurd cap would overflow the counter width
  if (WARM_MAX_LOG2 < 1 || WARM_MAX_LOG2 > DLY_W - 1) begin : g_chk
    $error("WARM_MAX_LOG2 out of range");
  end

  localparam logic [4:0] WARM_CAP = 5'(WARM_MAX_LOG2); // cap at register width

  acx_phase_e phase_r; // data phase in progress
  acx_phase_e phase_nxt; // next data phase
  logic [ADDR_W-1:0] addr_r; // latched address
  logic [31:0] hrdata_r; // read data flop
  logic take; // address phase accepted
  logic wr_en; // write data phase
  logic [15:0] wd; // write data, low half
  logic [15:0] rd_word; // read mux result
  logic [2*NUM_DED-1:0] insel_r; // input selectors
  logic [NUM_CORES-1:0] pwr_r; // power enables
  logic [WARM_W-1:0] warm_r; // warm-up code
  logic [NUM_CORES-1:0] cie_r; // ready interrupt enables
  logic [NUM_DED-1:0] mode_r; // differential mode bits
  logic [NUM_AN-1:0] eist_r; // early status
  logic [NUM_AN-1:0] eist_wr; // eist after software write
  logic [NUM_CORES-1:0] rdy_st_r; // sticky ready events
  logic [NUM_CORES-1:0] rmask_r; // ready event mask
  logic [NUM_CORES-1:0] rise_v; // ready event pulses
  logic [NUM_CORES-1:0] rdy_clr; // write-one-to-clear bits
  logic [NUM_DED-1:0][5:0] route_r; // route flops
  logic [NUM_DED-1:0] neg_r; // negative-input flops
  logic [4:0] warm_log2; // log2 of warm-up periods
  logic [DLY_W-1:0] warm_m1; // warm-up periods minus one

  // packs a core vector into the dedicated-low, shared-bit-7 byte layout
  function automatic logic [7:0] byte5(input logic [NUM_CORES-1:0] v);
    byte5 = {v[NUM_CORES-1], 3'h0, v[NUM_DED-1:0]};
  endfunction

  // inverse of byte5: unused bits 6:4 are dropped
  function automatic logic [NUM_CORES-1:0] unbyte5(input logic [7:0] b);
    unbyte5 = {b[SHR_POS], b[NUM_DED-1:0]};
  endfunction

  // ---------------- ahb-lite slave ----------------

  assign take = hsel && htrans[1] && hready;
  assign wr_en = (phase_r == ST_WR);
  assign wd = hwdata[15:0];
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  // reads stall one cycle so a write just before is already visible
  assign hreadyout = (phase_r != ST_RD_WAIT);

  // data phase sequencing
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      ST_IDLE, ST_WR, ST_RD_OUT: begin
        if (!take) begin
          phase_nxt = ST_IDLE;
        end else if (!hwrite) begin
          phase_nxt = ST_RD_WAIT;
        end else if (hsize == SIZE_WORD) begin
          phase_nxt = ST_WR;
        end else begin
          phase_nxt = ST_IDLE; // narrow writes are dropped
        end
      end
      ST_RD_WAIT: begin
        phase_nxt = ST_RD_OUT;
      end
      default: begin
        phase_nxt = ST_IDLE;
      end
    endcase
  end

  // phase register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phase_r <= ST_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // address latch; upper bits are decoded by the interconnect via hsel
  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_r <= '0;
    end else if (take) begin
      addr_r <= haddr[ADDR_W-1:0];
    end
  end

  // read mux; unmapped offsets and unused bits read zero
  always_comb begin
    rd_word = RST_REG;
    case (addr_r)
      OFS_INSEL: rd_word = {8'h00, insel_r};
      OFS_PWRRDY: rd_word = {byte5(core_ready), byte5(pwr_r)};
      OFS_WARMCIE: rd_word = {4'h0, warm_r, byte5(cie_r)};
      OFS_EIST_LO: rd_word = eist_r[EIST_LO_W-1:0];
      OFS_EIST_HI: rd_word = {10'h000, eist_r[NUM_AN-1:EIST_LO_W]};
      OFS_MODE: begin
        rd_word = RST_REG;
        for (int k = 0; k < NUM_DED; k++) begin
          rd_word[DIFF_POS[k]] = mode_r[k];
        end
      end
      OFS_RDY_ST: rd_word = {8'h00, byte5(rdy_st_r)};
      OFS_RDY_MASK: rd_word = {8'h00, byte5(rmask_r)};
      default: rd_word = RST_REG;
    endcase
  end

  // read data flop, loaded during the wait cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hrdata_r <= '0;
    end else if (phase_r == ST_RD_WAIT) begin
      hrdata_r <= {16'h0000, rd_word};
    end
  end

  // ---------------- control registers ----------------

  // input selectors
  always_ff @(posedge core_clk) begin
    if (reset) begin
      insel_r <= '0;
    end else if (wr_en && addr_r == OFS_INSEL) begin
      insel_r <= wd[2*NUM_DED-1:0];
    end
  end

  // power enables; ready bits in the upper byte are never written
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr_r <= '0;
    end else if (wr_en && addr_r == OFS_PWRRDY) begin
      pwr_r <= unbyte5(wd[7:0]);
    end
  end

  // warm-up code and ready interrupt enables
  always_ff @(posedge core_clk) begin
    if (reset) begin
      warm_r <= '0;
      cie_r <= '0;
    end else if (wr_en && addr_r == OFS_WARMCIE) begin
      warm_r <= wd[WARM_LSB +: WARM_W];
      cie_r <= unbyte5(wd[7:0]);
    end
  end

  // differential mode bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_r <= '0;
    end else if (wr_en && addr_r == OFS_MODE) begin
      for (int k = 0; k < NUM_DED; k++) begin
        mode_r[k] <= wd[DIFF_POS[k]];
      end
    end
  end

  // ready event mask
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rmask_r <= '0;
    end else if (wr_en && addr_r == OFS_RDY_MASK) begin
      rmask_r <= unbyte5(wd[7:0]);
    end
  end

  // ---------------- early interrupt status ----------------

  // software may write the bits directly; a buffer read clears one
  always_comb begin
    eist_wr = eist_r;
    if (wr_en && addr_r == OFS_EIST_LO) begin
      eist_wr[EIST_LO_W-1:0] = wd;
    end
    if (wr_en && addr_r == OFS_EIST_HI) begin
      eist_wr[NUM_AN-1:EIST_LO_W] = wd[EIST_HI_W-1:0];
    end
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eist_r <= '0;
    end else begin
      eist_r <= (eist_wr & ~result_buf_rd) | early_irq_evt;
    end
  end

  // ---------------- warm-up timers ----------------

  // warm-up length is 2^code periods (code 4 gives 16), capped for short simulations
  always_comb begin
    warm_log2 = {1'b0, warm_r};
    if (warm_log2 > WARM_CAP) begin
      warm_log2 = WARM_CAP;
    end
    warm_m1 = DLY_W'((32'd1 << warm_log2) - 32'd1);
  end

  acx_warm_if wif [NUM_CORES] ();

  genvar g;
  generate
    for (g = 0; g < NUM_CORES; g++) begin : g_warm
      assign wif[g].pwr_en = pwr_r[g];
      assign wif[g].delay_m1 = warm_m1;
      // gating by the enable drops ready in the same cycle power goes off
      assign core_ready[g] = wif[g].ready && pwr_r[g];
      assign rise_v[g] = wif[g].ready_rise && pwr_r[g];
      acx_warm_timer u_timer (
        .core_clk(core_clk),
        .reset(reset),
        .wp(wif[g])
      );
    end
  endgenerate

  assign core_power_en = pwr_r;

  // ---------------- ready interrupt ----------------

  assign rdy_clr = (wr_en && addr_r == OFS_RDY_ST) ? unbyte5(wd[7:0]) : '0;

  // sticky ready events; set wins over a write-one clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdy_st_r <= '0;
    end else begin
      rdy_st_r <= (rdy_st_r & ~rdy_clr) | (rise_v & cie_r);
    end
  end

  assign irq = |(rdy_st_r & rmask_r);

  // ---------------- input routing ----------------

  // registered so the analog switches see glitch-free codes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      route_r <= '0;
      neg_r <= '0;
    end else begin
      for (int k = 0; k < NUM_DED; k++) begin
        case (insel_r[SEL_W*k +: SEL_W])
          2'h0: route_r[k] <= ROUTE_CODE0[k];
          2'h1: route_r[k] <= ROUTE_CODE1[k];
          2'h2: route_r[k] <= ROUTE_CODE2[k];
          default: route_r[k] <= ROUTE_CODE3[k];
        endcase
        neg_r[k] <= mode_r[k] && (insel_r[SEL_W*k +: SEL_W] == SEL_NEG_CODE);
      end
    end
  end

  assign core_route = route_r;
  assign core_neg_sel = neg_r;

  // ---------------- checks ----------------

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence rd_hi_s;
    phase_r == ST_RD_WAIT && addr_r == OFS_EIST_HI;
  endsequence

  sequence pwr_wr_s;
    phase_r == ST_WR && addr_r == OFS_PWRRDY;
  endsequence

  core3_route_a: assert property (insel_r[7:6] == 2'h1 |=> core_route[3] == ROUTE_CODE1[3])
    else $error("core 3 route wrong");
  core2_route_a: assert property (insel_r[5:4] == 2'h2 |=> core_route[2] == ROUTE_BANDGAP)
    else $error("core 2 route wrong");
  core1_route_a: assert property (insel_r[3:2] == 2'h3 |=> core_route[1] == ROUTE_ALT1)
    else $error("core 1 route wrong");
  core0_route_a: assert property (insel_r[1:0] == 2'h2 |=> core_route[0] == ROUTE_GAIN1)
    else $error("core 0 route wrong");
  diff_neg_a: assert property (mode_r[1] && insel_r[3:2] == 2'h1 |=> core_neg_sel[1])
    else $error("negative input not flagged");
  ready_pwr_a: assert property ((core_ready & ~(core_power_en & $past(core_power_en))) == '0)
    else $error("ready without power");
  ready_hw_a: assert property (pwr_wr_s |=> (core_ready & ~$past(core_ready)) == '0)
    else $error("register write raised a ready flag");
  pwr_write_a: assert property (pwr_wr_s |=> core_power_en == unbyte5($past(hwdata[7:0])))
    else $error("power enable not written");
  eist_set_a: assert property (|early_irq_evt |=>
    (eist_r & $past(early_irq_evt)) == $past(early_irq_evt))
    else $error("early status not set");
  eist_clr_a: assert property (phase_r != ST_WR && |(result_buf_rd & ~early_irq_evt) |=>
    (eist_r & $past(result_buf_rd & ~early_irq_evt)) == '0)
    else $error("early status not cleared");
  eist_hi_a: assert property (rd_hi_s ##1 hreadyout |-> hrdata[31:EIST_HI_W] == '0)
    else $error("unused status bits not zero");
  cie_gate_a: assert property ((rdy_st_r & ~$past(rdy_st_r) & ~$past(cie_r)) == '0)
    else $error("disabled ready event latched");
  irq_level_a: assert property (|(rise_v & cie_r & rmask_r) &&
    !(wr_en && addr_r == OFS_RDY_MASK) |=> irq)
    else $error("enabled ready event did not raise interrupt");
endmodule

//--- tb/acx_core_ctrl_tb.sv
`timescale 1ns/1ps
// one comparison: counts it, and reports and counts a mismatch
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, a); end end
module acx_core_ctrl_tb import acx_pkg::*;;
  // expected source per core for selector codes 01, 10 and 11
  localparam logic [5:0] RT1 [4] = '{6'd7, 6'd18, 6'd11, 6'd15};
  localparam acx_route_t RT2 [4] = '{ROUTE_GAIN1, ROUTE_GAIN2, ROUTE_BANDGAP, ROUTE_NONE};
  localparam acx_route_t RT3 [4] = '{ROUTE_ALT0, ROUTE_ALT1, ROUTE_NONE, ROUTE_NONE};
  localparam logic [23:0] RT_RST = {6'd3, 6'd2, 6'd1, 6'd0}; // selectors at 00
  localparam int CODES [5] = '{0, 1, 3, 4, 15}; // warm-up codes, the top one capped
  logic core_clk = 1'b0; // 40 mhz core clock
  logic reset = 1'b1; // synchronous reset
  logic hsel = 1'b0; // bus select
  logic [31:0] haddr = '0; // bus address
  logic [1:0] htrans = 2'b00; // bus transfer type
  logic hwrite = 1'b0; // bus direction
  logic [2:0] hsize = 3'h2; // bus size
  logic [31:0] hwdata = '0; // bus write data
  logic hready; // slave ready, fed back as bus ready
  logic hresp; // slave response
  logic [31:0] hrdata; // slave read data
  logic [NUM_AN-1:0] early_irq_evt = '0; // early event pulses
  logic [NUM_AN-1:0] result_buf_rd = '0; // result buffer read pulses
  logic [NUM_DED-1:0][5:0] core_route; // routed source per core
  logic [NUM_DED-1:0] core_neg_sel; // negative input flags
  logic [NUM_CORES-1:0] core_power_en; // power enables
  logic [NUM_CORES-1:0] core_ready; // ready flags
  logic irq; // common interrupt
  int fail_count = 0; // mismatches
  int compares = 0; // comparisons made
  int seed = 32'h5454091d; // fixed random seed
  logic [31:0] exp_q [$]; // expected read data, oldest first
  logic [31:0] exp_v; // note taken off the queue
  logic rd_dp = 1'b0; // a read is in its data phase

  always #12.5 core_clk = ~core_clk;

  // warm-up capped at 16 cycles so the long codes stay short
  acx_core_ctrl #(.WARM_MAX_LOG2(4)) i_dut (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .early_irq_evt(early_irq_evt),
    .result_buf_rd(result_buf_rd), .core_route(core_route), .core_neg_sel(core_neg_sel),
    .core_power_en(core_power_en), .core_ready(core_ready), .irq(irq)
  );

  // expected source code of core k for selector code c
  function automatic logic [5:0] exp_route(input int k, input int c);
    case (c)
      0: return 6'(k);
      1: return RT1[k];
      2: return RT2[k];
      default: return RT3[k];
    endcase
  endfunction

  // one single transfer; holds each phase until ready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= sz;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    // a read leaves its expected word for the monitor
    if (!w) exp_q.push_back(d);
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 3'h2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, e, 3'h2);
  endtask

  // monitor: a read result appears when ready is high in a read data phase
  always @(posedge core_clk) begin
    if (rd_dp && hready === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK("hrdata", exp_v, hrdata)
      `CHK("hresp", 1'b0, hresp)
    end
    if (hready === 1'b1) rd_dp = hsel & htrans[1] & ~hwrite;
  end

  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end

  // main sequence
  initial begin
    logic [31:0] ev, cl;
    logic [7:0] cie;
    int n;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    // reset state: routes at code 00, every register zero, unmapped 0x20 too
    `CHK("route", RT_RST, core_route)
    `CHK("power", 5'h0, core_power_en)
    for (int a = 0; a < 36; a += 4) rd(8'(a), 32'h0);
    // every selector code on every core, differential mode off and on
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 2; d++) begin
        wr(8'h00, 32'hffffff00 | (c * 32'h55));
        wr(8'h14, d ? 32'haa : 32'h0);
        repeat (2) @(posedge core_clk);
        for (int k = 0; k < 4; k++) `CHK("route", exp_route(k, c), core_route[k])
        `CHK("neg_sel", (d && c == 1) ? 4'hf : 4'h0, core_neg_sel)
        rd(8'h00, c * 32'h55);
      end
    end
    // early status: random events, then random buffer reads clear them
    for (int r = 0; r < 4; r++) begin
      ev = $random(seed);
      cl = $random(seed);
      result_buf_rd <= '1;
      @(posedge core_clk);
      result_buf_rd <= '0;
      early_irq_evt <= ev[21:0];
      @(posedge core_clk);
      early_irq_evt <= '0;
      rd(8'h0c, {16'h0, ev[15:0]});
      rd(8'h10, {26'h0, ev[21:16]});
      // an event in the clearing cycle must win over the clear
      result_buf_rd <= cl[21:0];
      early_irq_evt <= cl[21:0] & ~ev[21:0];
      @(posedge core_clk);
      result_buf_rd <= '0;
      early_irq_evt <= '0;
      rd(8'h0c, {16'h0, ev[15:0] ^ cl[15:0]});
      rd(8'h10, {26'h0, ev[21:16] ^ cl[21:16]});
    end
    wr(8'h10, 32'hffff);
    rd(8'h10, 32'h3f);
    // warm-up per code; ready events raise the interrupt through status and mask
    wr(8'h1c, 32'h8f);
    for (int i = 0; i < 5; i++) begin
      cie = 8'($random(seed)) & 8'h8f;
      n = (CODES[i] >= 4) ? 16 : (1 << CODES[i]);
      wr(8'h08, {20'h0, 4'(CODES[i]), cie});
      wr(8'h04, 32'h8f);
      repeat (n) @(posedge core_clk);
      `CHK("ready_early", 5'h0, core_ready)
      @(posedge core_clk);
      `CHK("ready", 5'h1f, core_ready)
      `CHK("power", 5'h1f, core_power_en)
      rd(8'h04, 32'h8f8f);
      rd(8'h18, {24'h0, cie});
      `CHK("irq", |cie, irq)
      // masked off, the set status no longer reaches the line
      wr(8'h1c, 32'h0);
      repeat (2) @(posedge core_clk);
      `CHK("irq_masked", 1'b0, irq)
      wr(8'h1c, 32'h8f);
      wr(8'h18, {24'h0, cie});
      repeat (2) @(posedge core_clk);
      `CHK("irq_cleared", 1'b0, irq)
      // ready bits ignore the write; clearing power drops ready
      wr(8'h04, 32'hff00);
      rd(8'h04, 32'h0);
      `CHK("ready_off", 5'h0, core_ready)
    end
    // a halfword write is dropped
    xfer(8'h08, 1'b1, 32'h0, 3'h1);
    rd(8'h08, {20'h0, 4'hf, cie});
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule
